// file: hdl/encoder_control_status_preset.sv
// Control word decode, preset handling, status word and secondary word of the encoder.
// Assumes all inputs are produced on REF_CLK_IN by the telegram and sensor logic.
`timescale 1ns/1ps
`default_nettype none
`include "encoder_ctl_map.svh"

// Operation
// - Decode command word bits 11 to 15; lower bits ignored.
// - While parked, stay on bus, keep sign-of-life, suppress diagnostics and errors.
// - Command bit 11 zero selects absolute preset, one selects relative shift.
// - Command bit 12 low leaves the output position unchanged.
// - Absolute preset sets offset so shifted position equals preset value.
// - Set preset-done after a preset; clear it when command bit 12 drops.
// - Relative preset adds the signed preset value to the offset.
// - Each preset stores the offset in memory; offset reloads at power-on.
// - Preset value is zero until the master writes another.
// - Command bit 13 sends the absolute position in the secondary word.
// - Parking stops fault monitoring and clears pending sensor errors.
// - Parking while the drive runs is refused with error code 0x03.
// - Command bit 15 acknowledges and clears the sensor error.
// - Condition word flags ack-required, preset-done, cyclic, parked, sensor error.
// - Without bit 13 or 15 the secondary word carries nothing valid.
// - Condition bits 13 and 15 are never set together.
// - Signed 32-bit velocity recomputed once every 100 ms.
// - An active error places its code in the secondary word.
// - Master sign-of-life failures exceeded report code 0x0F02.
// - Bus cycle synchronisation failures exceeded report code 0x0F04.
// - Non-volatile memory failure reports code 0x1001.
// - Inconsistent startup parameters report code 0x1002.
// - No error and no cyclic request drive the secondary word to zero.
module encoder_control_status_preset #(
  parameter int unsigned VEL_PERIOD_CYCLES = `VEL_PERIOD_CYC
) (
  input wire logic REF_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic [15:0] COMMAND_WORD_IN,
  input wire logic COMMAND_VALID_IN,
  input wire logic [31:0] PRESET_TARGET_IN,
  input wire logic PRESET_TARGET_VALID_IN,
  input wire logic [31:0] RAW_POSITION_IN,
  input wire logic DRIVE_RUNNING_IN,
  input wire logic MASTER_LIFE_FAULT_IN,
  input wire logic SYNC_FAULT_IN,
  input wire logic NVM_FAULT_IN,
  input wire logic PARAM_FAULT_IN,
  input wire logic [31:0] NVM_OFFSET_IN,
  input wire logic NVM_LOAD_VALID_IN,
  output logic [15:0] CONDITION_WORD_OUT,
  output logic [31:0] PRIMARY_POSITION_OUT,
  output logic [31:0] SECONDARY_POSITION_OUT,
  output logic [31:0] VELOCITY_OUT,
  output logic NVM_WRITE_OUT,
  output logic [31:0] NVM_DATA_OUT,
  output logic [3:0] LIFE_COUNT_OUT,
  output logic DIAG_ENABLE_OUT
);

  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  // Highest priority first; one code fits the secondary word at a time
  function automatic encoder_ctl_pkg::pos_word_t fault_code(
    input encoder_ctl_pkg::fault_vec_t f
  );
    encoder_ctl_pkg::pos_word_t c;
    c = `WORD_RESET;
    if (f[4]) begin
      c = `ERR_PARK_REFUSED;
    end else if (f[3]) begin
      c = `ERR_PARAM;
    end else if (f[2]) begin
      c = `ERR_MEMORY;
    end else if (f[1]) begin
      c = `ERR_SYNC;
    end else if (f[0]) begin
      c = `ERR_MASTER_LIFE;
    end
    return c;
  endfunction : fault_code

  encoder_ctl_pkg::ctl_word_t cmd_q;
  encoder_ctl_pkg::ctl_word_t cmd_d;
  encoder_ctl_pkg::pos_word_t preset_q;
  encoder_ctl_pkg::pos_word_t preset_d;
  encoder_ctl_pkg::pos_word_t offset_q;
  encoder_ctl_pkg::pos_word_t offset_d;
  encoder_ctl_pkg::preset_state_t pstate_q;
  encoder_ctl_pkg::preset_state_t pstate_d;
  logic prev_preset_q;
  logic prev_park_q;
  logic park_q;
  logic park_d;
  logic err_q;
  logic err_d;
  encoder_ctl_pkg::pos_word_t err_code_q;
  encoder_ctl_pkg::pos_word_t err_code_d;
  encoder_ctl_pkg::ctl_word_t cond_q;
  encoder_ctl_pkg::ctl_word_t cond_d;
  encoder_ctl_pkg::pos_word_t prim_q;
  encoder_ctl_pkg::pos_word_t sec_q;
  encoder_ctl_pkg::pos_word_t sec_d;
  encoder_ctl_pkg::pos_word_t vel_q;
  encoder_ctl_pkg::pos_word_t vel_d;
  encoder_ctl_pkg::pos_word_t last_pos_q;
  logic [24:0] vel_cnt_q;
  logic nvm_wr_q;
  encoder_ctl_pkg::pos_word_t nvm_data_q;
  logic [3:0] life_q;
  logic [3:0] life_d;
  logic diag_q;

  wire logic home_rel = cmd_q[`CMD_HOME_MODE_BIT];
  wire logic req_preset = cmd_q[`CMD_PRESET_BIT];
  wire logic req_cyclic = cmd_q[`CMD_CYCLIC_BIT];
  wire logic req_park = cmd_q[`CMD_PARK_BIT];
  wire logic req_ack = cmd_q[`CMD_ACK_BIT];

  // Telegram words are captured only when the telegram logic marks them new
  assign cmd_d = COMMAND_VALID_IN ? COMMAND_WORD_IN : cmd_q;
  assign preset_d = PRESET_TARGET_VALID_IN ? PRESET_TARGET_IN : preset_q;

  // Rising edge only, so a held request cannot fire twice
  wire logic preset_fire = req_preset & ~prev_preset_q &
    (pstate_q == encoder_ctl_pkg::PRESET_IDLE);
  wire encoder_ctl_pkg::pos_word_t abs_offset = preset_q - RAW_POSITION_IN;
  wire encoder_ctl_pkg::pos_word_t rel_offset = offset_q + preset_q;
  wire encoder_ctl_pkg::pos_word_t new_offset = home_rel ? rel_offset : abs_offset;

  // Offset is reloaded from memory after power-on; a preset overrides a late reload
  assign offset_d = preset_fire ? new_offset :
    (NVM_LOAD_VALID_IN ? NVM_OFFSET_IN : offset_q);

  always_comb begin
    pstate_d = pstate_q;
    case (pstate_q)
      encoder_ctl_pkg::PRESET_IDLE: begin
        if (preset_fire) begin
          pstate_d = encoder_ctl_pkg::PRESET_DONE;
        end
      end
      encoder_ctl_pkg::PRESET_DONE: begin
        if (!req_preset) begin
          pstate_d = encoder_ctl_pkg::PRESET_IDLE;
        end
      end
      default: begin
        pstate_d = encoder_ctl_pkg::PRESET_IDLE;
      end
    endcase
  end

  // Parking is granted only while the drive stands; once granted it holds
  wire logic park_rise = req_park & ~prev_park_q;
  wire logic park_refuse = park_rise & ~park_q & DRIVE_RUNNING_IN;
  assign park_d = req_park & (park_q | ~DRIVE_RUNNING_IN);
  wire logic park_enter = park_d & ~park_q;

  // Parked sensor monitors nothing, so faults are masked
  wire encoder_ctl_pkg::fault_vec_t faults = {park_refuse,
    PARAM_FAULT_IN & ~park_q,
    NVM_FAULT_IN & ~park_q,
    SYNC_FAULT_IN & ~park_q,
    MASTER_LIFE_FAULT_IN & ~park_q};
  wire logic fault_any = |faults;

  // A fault in the same cycle as an acknowledge or park entry stays pending
  assign err_d = fault_any ? 1'b1 : ((park_enter | req_ack) ? 1'b0 : err_q);
  assign err_code_d = fault_any ? fault_code(faults) :
    (err_d ? err_code_q : `WORD_RESET);

  wire encoder_ctl_pkg::pos_word_t shifted_pos = RAW_POSITION_IN + offset_q;
  wire logic cyclic_on = req_cyclic & ~err_d;

  always_comb begin
    cond_d = 16'h0000;
    cond_d[`ST_ACK_REQ_BIT] = err_d;
    cond_d[`ST_PRESET_DONE_BIT] = (pstate_d == encoder_ctl_pkg::PRESET_DONE);
    cond_d[`ST_CYCLIC_BIT] = cyclic_on;
    cond_d[`ST_PARK_BIT] = park_d;
    cond_d[`ST_ERROR_BIT] = err_d;
  end

  // Error code replaces the position; otherwise zero unless cyclic is asked
  assign sec_d = err_d ? err_code_d :
    (cyclic_on ? shifted_pos : `WORD_RESET);

  // Velocity is the step difference per period scaled to steps per second
  wire logic vel_tick = (vel_cnt_q == 25'(VEL_PERIOD_CYCLES - 1));
  wire encoder_ctl_pkg::pos_word_t vel_delta = shifted_pos - last_pos_q;
  assign vel_d = vel_tick ? 32'(vel_delta * `VEL_SCALE) : vel_q;

  // Sign-of-life keeps counting while parked; zero is skipped on wrap
  assign life_d = ~COMMAND_VALID_IN ? life_q :
    ((life_q == `LIFE_LAST) ? `LIFE_FIRST : life_q + 4'h1);

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      cmd_q <= `CMD_RESET;
      preset_q <= `PRESET_RESET;
      offset_q <= `WORD_RESET;
      pstate_q <= encoder_ctl_pkg::PRESET_IDLE;
      prev_preset_q <= 1'b0;
      prev_park_q <= 1'b0;
      park_q <= 1'b0;
    end else begin
      cmd_q <= cmd_d;
      preset_q <= preset_d;
      offset_q <= offset_d;
      pstate_q <= pstate_d;
      prev_preset_q <= req_preset;
      prev_park_q <= req_park;
      park_q <= park_d;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      err_q <= 1'b0;
      err_code_q <= `WORD_RESET;
      cond_q <= `CMD_RESET;
      prim_q <= `WORD_RESET;
      sec_q <= `WORD_RESET;
      life_q <= `LIFE_RESET;
      diag_q <= 1'b1;
    end else begin
      err_q <= err_d;
      err_code_q <= err_code_d;
      cond_q <= cond_d;
      prim_q <= shifted_pos;
      sec_q <= sec_d;
      life_q <= life_d;
      diag_q <= ~park_d;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      vel_cnt_q <= 25'h000_0000;
      vel_q <= `WORD_RESET;
      last_pos_q <= `WORD_RESET;
    end else begin
      vel_cnt_q <= vel_tick ? 25'h000_0000 : vel_cnt_q + 25'h000_0001;
      vel_q <= vel_d;
      last_pos_q <= vel_tick ? shifted_pos : last_pos_q;
    end
  end

  // Store request is a one-cycle strobe carrying the freshly computed offset
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      nvm_wr_q <= 1'b0;
      nvm_data_q <= `WORD_RESET;
    end else begin
      nvm_wr_q <= preset_fire;
      nvm_data_q <= preset_fire ? new_offset : nvm_data_q;
    end
  end

  assign CONDITION_WORD_OUT = cond_q;
  assign PRIMARY_POSITION_OUT = prim_q;
  assign SECONDARY_POSITION_OUT = sec_q;
  assign VELOCITY_OUT = vel_q;
  assign NVM_WRITE_OUT = nvm_wr_q;
  assign NVM_DATA_OUT = nvm_data_q;
  assign LIFE_COUNT_OUT = life_q;
  assign DIAG_ENABLE_OUT = diag_q;

  chk_flags_exclusive: assert property (
    !(cond_q[`ST_CYCLIC_BIT] && cond_q[`ST_ERROR_BIT]))
    else $error("cyclic and error flags set together");

  chk_abs_preset: assert property (
    preset_fire && !home_rel |=> offset_q == $past(preset_q) - $past(RAW_POSITION_IN))
    else $error("absolute preset offset wrong");

  chk_rel_preset: assert property (
    preset_fire && home_rel |=> offset_q == $past(offset_q) + $past(preset_q))
    else $error("relative preset offset wrong");

  chk_preset_ack_cycle: assert property (
    preset_fire |=> cond_q[`ST_PRESET_DONE_BIT] ##1
      (!req_preset [*1] or cond_q[`ST_PRESET_DONE_BIT]))
    else $error("preset done flag not set after preset");

  chk_ack_release: assert property (
    cond_q[`ST_PRESET_DONE_BIT] && !req_preset && !preset_fire
      |=> !cond_q[`ST_PRESET_DONE_BIT])
    else $error("preset done flag not cleared");

  chk_single_preset: assert property (
    cond_q[`ST_PRESET_DONE_BIT] && req_preset |=> !nvm_wr_q)
    else $error("second preset in one request cycle");

  chk_offset_store: assert property (
    preset_fire |=> nvm_wr_q && nvm_data_q == offset_q ##1 !nvm_wr_q)
    else $error("offset not stored after preset");

  chk_idle_secondary: assert property (
    !err_d && !req_cyclic |=> sec_q == 32'h0000_0000)
    else $error("secondary word not zero when idle");

  chk_error_in_secondary: assert property (
    err_q |-> sec_q == err_code_q && cond_q[`ST_ERROR_BIT])
    else $error("error code missing from secondary word");

  chk_park_refused: assert property (
    park_refuse |=> err_q && !park_q && !cond_q[`ST_PARK_BIT])
    else $error("running park not refused");

  chk_error_ack: assert property (
    err_q && req_ack && !fault_any |=> !err_q [*1] ##0 !cond_q[`ST_ERROR_BIT])
    else $error("acknowledge did not clear error");

  chk_velocity_hold: assert property (
    !vel_tick |=> vel_q == $past(vel_q))
    else $error("velocity changed between periods");

  chk_diag_parked: assert property (
    park_q |-> !DIAG_ENABLE_OUT && cond_q[`ST_PARK_BIT])
    else $error("diagnostics still enabled while parked");

  chk_life_advance: assert property (
    COMMAND_VALID_IN |=> life_q != $past(life_q) && life_q != 4'h0)
    else $error("sign-of-life did not advance");

  chk_park_clears_error: assert property (
    park_enter && !fault_any |=> !err_q && !cond_q[`ST_ERROR_BIT])
    else $error("parking did not clear pending errors");

  chk_offset_hold: assert property (
    !preset_fire && !NVM_LOAD_VALID_IN |=> offset_q == $past(offset_q))
    else $error("offset changed without a preset");

  chk_cyclic_position: assert property (
    req_cyclic && !err_d |=> sec_q == $past(shifted_pos) && cond_q[`ST_CYCLIC_BIT])
    else $error("cyclic position missing from secondary word");

endmodule : encoder_control_status_preset
`default_nettype wire

// file: pkg/encoder_ctl_map.svh
// Bit positions, reset values, error codes and timing counts of the encoder control block.
// Assumes it is included by its bare name wherever these constants are needed.
`ifndef ENCODER_CTL_MAP_SVH
`define ENCODER_CTL_MAP_SVH

// Command word bits
`define CMD_HOME_MODE_BIT 11
`define CMD_PRESET_BIT 12
`define CMD_CYCLIC_BIT 13
`define CMD_PARK_BIT 14
`define CMD_ACK_BIT 15

// Condition word bits
`define ST_ACK_REQ_BIT 11
`define ST_PRESET_DONE_BIT 12
`define ST_CYCLIC_BIT 13
`define ST_PARK_BIT 14
`define ST_ERROR_BIT 15

// Reset values
`define CMD_RESET 16'h0000
`define WORD_RESET 32'h0000_0000
`define PRESET_RESET 32'h0000_0000
`define LIFE_RESET 4'h0
`define LIFE_FIRST 4'h1
`define LIFE_LAST 4'hF

// Error codes placed in the secondary position word
`define ERR_PARK_REFUSED 32'h0000_0003
`define ERR_MASTER_LIFE 32'h0000_0F02
`define ERR_SYNC 32'h0000_0F04
`define ERR_MEMORY 32'h0000_1001
`define ERR_PARAM 32'h0000_1002

// Timing
`define CLK_FREQ_KHZ 200000
`define VEL_PERIOD_MS 100
`define VEL_PERIOD_CYC (`VEL_PERIOD_MS * `CLK_FREQ_KHZ)
`define VEL_SCALE (1000 / `VEL_PERIOD_MS)

`endif

// file: pkg/encoder_ctl_pkg.sv
// Types shared by the encoder control block.
// Assumes the map header supplies all numeric constants.
package encoder_ctl_pkg;
  typedef logic [15:0] ctl_word_t;
  typedef logic [31:0] pos_word_t;
  typedef logic [4:0] fault_vec_t;
  typedef enum logic {PRESET_IDLE, PRESET_DONE} preset_state_t;
endpackage : encoder_ctl_pkg

// file: sim/master_model.sv
// Bench model of the fieldbus master: command word and preset handshake.
// Assumes the bench holds the base word and pulses start_in for one clock.
`timescale 1ns/1ps
`default_nettype none
`include "encoder_ctl_map.svh"
module master_model (
  input wire logic clk_in,
  input wire logic [15:0] base_in,
  input wire logic start_in,
  input wire logic [15:0] cond_in,
  output logic [15:0] cmd_out
);
  logic req_q = 1'b0;
  // Request held until the acknowledge is seen, only then dropped
  always @(posedge clk_in) begin
    if (start_in) begin
      req_q <= 1'b1;
    end else if (cond_in[`ST_PRESET_DONE_BIT]) begin
      req_q <= 1'b0;
    end
  end
  always_comb begin
    cmd_out = base_in;
    cmd_out[`CMD_PRESET_BIT] = req_q;
  end
endmodule : master_model
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the encoder control block.
// Assumes the map header and the master model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "encoder_ctl_map.svh"
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, cv = 1'b0, tv = 1'b0, run = 1'b0, load = 1'b0, start = 1'b0;
  logic [3:0] flt = 4'h0;
  logic [31:0] tgt = 32'h0000_0000, raw = 32'h0000_0000, noff = 32'h0000_0000, off_exp;
  logic [15:0] base = 16'h0000, cmd, cond;
  logic [31:0] prim, sec, vel, ndata;
  logic nwr, diag;
  logic [3:0] life, life0;
  logic [31:0] step;
  logic [31:0] codes [4] = '{`ERR_MASTER_LIFE, `ERR_SYNC, `ERR_MEMORY, `ERR_PARAM};
  int n_fail = 0, n_compared = 0, n_wr = 0, seed = 38;
  // Short velocity period keeps the run small; the scale factor is unchanged
  localparam int SIM_VEL_CYC = 16;
  master_model peer (.clk_in(clk), .base_in(base), .start_in(start), .cond_in(cond),
    .cmd_out(cmd));
  encoder_control_status_preset #(.VEL_PERIOD_CYCLES(SIM_VEL_CYC)) uut (.REF_CLK_IN(clk),
    .RESET_N_IN(rst_n), .COMMAND_WORD_IN(cmd), .COMMAND_VALID_IN(cv),
    .PRESET_TARGET_IN(tgt), .PRESET_TARGET_VALID_IN(tv), .RAW_POSITION_IN(raw),
    .DRIVE_RUNNING_IN(run), .MASTER_LIFE_FAULT_IN(flt[0]), .SYNC_FAULT_IN(flt[1]),
    .NVM_FAULT_IN(flt[2]), .PARAM_FAULT_IN(flt[3]), .NVM_OFFSET_IN(noff),
    .NVM_LOAD_VALID_IN(load), .CONDITION_WORD_OUT(cond), .PRIMARY_POSITION_OUT(prim),
    .SECONDARY_POSITION_OUT(sec), .VELOCITY_OUT(vel), .NVM_WRITE_OUT(nwr),
    .NVM_DATA_OUT(ndata), .LIFE_COUNT_OUT(life), .DIAG_ENABLE_OUT(diag));
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (nwr === 1'b1) n_wr++;
  end
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      n_fail++;
    end
  endtask : check
  // Steady ramp: steps of one period scaled to steps per second
  function automatic logic [31:0] vel_exp(input logic [31:0] s);
    return 32'(s * SIM_VEL_CYC * `VEL_SCALE);
  endfunction : vel_exp
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Bounded wait for one condition bit; a stall ends the run
  task automatic wait_bit(input int b, input logic v);
    int i;
    for (i = 0; i < 50 && cond[b] !== v; i++) tick(1);
    if (cond[b] !== v) begin
      $display("BAD %0t status wait timed out", $time);
      n_fail++;
      print_verdict();
    end
  endtask : wait_bit
  task automatic preset(input logic rel, input logic [31:0] v, input logic wr);
    @(posedge clk);
    tgt <= v;
    tv <= wr;
    base[`CMD_HOME_MODE_BIT] <= rel;
    @(posedge clk);
    tv <= 1'b0;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    wait_bit(`ST_PRESET_DONE_BIT, 1'b1);
    off_exp = rel ? off_exp + v : v - raw;
    tick(1);
    check(prim, raw + off_exp, "preset position");
    check(ndata, off_exp, "stored offset");
    wait_bit(`ST_PRESET_DONE_BIT, 1'b0);
  endtask : preset
  task automatic ack;
    @(posedge clk);
    base[`CMD_ACK_BIT] <= 1'b1;
    tick(3);
    base[`CMD_ACK_BIT] <= 1'b0;
    tick(3);
    check(cond[`ST_ERROR_BIT], 1'b0, "error not cleared");
  endtask : ack
  initial begin
    tick(2);
    check(cond, 32'h0000_0000, "condition after reset");
    check(diag, 1'b1, "diagnostics after reset");
    rst_n <= 1'b1;
    @(posedge clk);
    cv <= 1'b1;
    raw <= $random(seed);
    noff <= $random(seed);
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    off_exp = noff;
    tick(2);
    check(prim, raw + off_exp, "reloaded offset");
    $display("reload test done");
    preset(1'b0, 32'h0000_0000, 1'b0);
    preset(1'b1, 32'h0000_03E8, 1'b1);
    // Targets kept within 30 bits, as the master must
    repeat (4) preset($random(seed) & 1, $random(seed) & 32'h3FFF_FFFF, 1'b1);
    check(n_wr, 6, "offset store count");
    repeat (10) begin
      @(posedge clk);
      raw <= $random(seed);
      tick(2);
      check(prim, raw + off_exp, "position unshifted");
    end
    $display("preset tests done");
    base[`CMD_CYCLIC_BIT] <= 1'b1;
    tick(3);
    check(cond[`ST_CYCLIC_BIT], 1'b1, "cyclic flag");
    check(sec, raw + off_exp, "cyclic position");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      flt <= 4'h1 << i;
      @(posedge clk);
      flt <= 4'h0;
      tick(1);
      check(sec, codes[i], "error code");
      check({cond[15], cond[13], cond[11]}, 3'b101, "error flags");
      ack();
      check(sec, raw + off_exp, "position back");
    end
    base[`CMD_CYCLIC_BIT] <= 1'b0;
    tick(3);
    check(sec, 32'h0000_0000, "idle secondary");
    $display("error tests done");
    run <= 1'b1;
    base[`CMD_PARK_BIT] <= 1'b1;
    tick(3);
    check(sec, `ERR_PARK_REFUSED, "park refusal code");
    check(cond[`ST_PARK_BIT], 1'b0, "park refused");
    base[`CMD_PARK_BIT] <= 1'b0;
    run <= 1'b0;
    ack();
    @(posedge clk);
    flt <= 4'h2;
    @(posedge clk);
    base[`CMD_PARK_BIT] <= 1'b1;
    flt <= 4'h0;
    tick(4);
    check({cond[15], cond[14], diag}, 3'b010, "parked");
    life0 = life;
    @(posedge clk);
    flt <= 4'h4;
    run <= 1'b1;
    tick(3);
    check(cond[`ST_ERROR_BIT], 1'b0, "fault while parked");
    check(life != life0, 1'b1, "sign-of-life stopped");
    flt <= 4'h0;
    run <= 1'b0;
    base[`CMD_PARK_BIT] <= 1'b0;
    tick(4);
    check({cond[14], diag}, 2'b01, "unparked");
    $display("park tests done");
    // Ramp long enough that the latest period lies wholly inside it
    for (int k = 0; k < 2; k++) begin
      step = $random(seed) & 32'h0000_00FF;
      if (k == 1) begin
        step = -step;
      end
      repeat (48) begin
        @(posedge clk);
        raw <= raw + step;
      end
      #1;
      check(vel, vel_exp(step), "velocity on ramp");
    end
    tick(40);
    check(vel, 32'h0000_0000, "velocity at rest");
    $display("velocity tests done");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
